// >>> verilog/pilc_pkg.sv
// Constants and types shared by the interrupt latch controller
package pilc_pkg;

	// Special-function register byte addresses
	localparam logic [7:0] ADDR_ENABLE_UPPER = 8'h2C;
	localparam logic [7:0] ADDR_LATCH_UPPER = 8'h2E;
	localparam logic [7:0] ADDR_ENABLE_LOW = 8'h3A;
	localparam logic [7:0] ADDR_ENABLE_HIGH = 8'h3B;
	localparam logic [7:0] ADDR_LATCH_LOW = 8'h3C;
	localparam logic [7:0] ADDR_LATCH_HIGH = 8'h3D;

	// Source numbering: latch index equals source number
	localparam int NUM_SRC = 24;
	localparam int SRC_TRAP = 2;
	localparam int SRC_WDOG = 3;
	localparam int SRC_EXT0 = 4;
	localparam int SRC_FIRST_MASKABLE = 4;
	localparam int SRC_BANK2 = 16;
	localparam int SRC_CONVERTER = 15;
	localparam int IDX_W = 5;

	// Bit layout of the enable and latch words
	localparam int MASTER_ENABLE_BIT = 0;
	localparam logic [23:0] LATCH_IMPL_MASK = 24'hFF_FFFC;
	localparam logic [23:0] ENABLE_IMPL_MASK = 24'hFF_FFF0;
	localparam logic [23:0] LATCH_RESET = 24'h00_0000;
	localparam logic [23:0] ENABLE_RESET = 24'h00_0000;
	localparam logic RESET_MASTER_ENABLE = 1'b0;

	// Vector addresses
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_SOFT = 16'hFFFC;
	localparam logic [15:0] VEC_TRAP = 16'hFFFA;
	localparam logic [15:0] VEC_WDOG = 16'hFFF8;
	localparam logic [15:0] VEC_BANK1_TOP = 16'hFFF6;
	localparam logic [15:0] VEC_BANK2_TOP = 16'hFFBE;

	// Acceptance sequence
	localparam int ACCEPT_MACHINE_CYCLES = 8;
	localparam int PUSH_BYTES = 3;
	localparam logic [2:0] STEP_PUSH_PSW = 3'h1;
	localparam logic [2:0] STEP_PUSH_PCH = 3'h2;
	localparam logic [2:0] STEP_PUSH_PCL = 3'h3;
	localparam int PSW_IMF_BIT = 0;

	typedef enum logic {
		ST_IDLE,
		ST_ACCEPT
	} pilc_state_t;

	// One stack write toward the CPU memory port
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} pilc_push_t;

	// Register-file access from the CPU core
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pilc_sfr_t;

endpackage

// >>> verilog/pilc_top.sv
// Prioritized interrupt latch controller for an 8-bit CPU core
// Notes on behaviour
// - Twenty-four sources besides reset; four non-maskable, the rest maskable.
// - Nesting allowed: a handler that re-enables may be interrupted.
// - A request sets its latch; CPU is asked only when enabled.
// - Maskable source eligible only with master enable and its own enable.
// - Fixed priority: reset, non-maskable group, then latches 4 to 23.
// - Non-maskable sources share one level; reset alone on top at FFFE.
// - Software and bad-opcode interrupts use FFFC and have no latch.
// - Address trap is non-maskable, latch 2, vector FFFA.
// - Watchdog is non-maskable, latch 3, vector FFF8.
// - External 0 needs master enable, enable 4, and its pin enable.
// - Latches 4-15 vector FFF6 down to FFE0, 16-23 FFBE to FFB0.
// - Converter-done latch loss hazard during lower-priority acceptance; here a same-cycle request survives.
// - Every source except software and bad-opcode owns latch 2 to 23.
// - Accepting a source clears its latch at once.
// - Reset clears every latch.
// - Latches mapped at 002E, 003C and 003D.
// - Writing zero clears a latch; writing one leaves it unchanged.
// - Latch registers read back current pending state.
// - Acceptance saves then clears master enable; return restores it.
// - Master enable is bit 0 of enable_reg_low at 003A, resets zero.
// - Acceptance takes eight machine cycles after the instruction ends.
// - Acceptance pushes status with enable, PC high, PC low; SP minus 3.
`timescale 1ns/1ps

module pilc_top #(
	parameter int ACCEPT_CYCLES = pilc_pkg::ACCEPT_MACHINE_CYCLES
) (
	// Clock, reset, clock enable
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	// Interrupt sources, one-cycle pulses, index equals latch number
	input wire logic [pilc_pkg::NUM_SRC-1:0] i_src_req,
	input wire logic i_software_irq,
	input wire logic i_bad_opcode_irq,
	input wire logic i_ext0_pin_enable,
	// Special-function register access
	input wire pilc_pkg::pilc_sfr_t i_sfr,
	output logic [7:0] o_sfr_rdata,
	// CPU control
	input wire logic i_insn_done,
	input wire logic i_enable_op,
	input wire logic i_disable_op,
	input wire logic i_return_op,
	input wire logic i_return_imf,
	input wire logic [7:0] i_psw,
	input wire logic [15:0] i_pc,
	input wire logic [15:0] i_sp,
	// Acceptance outputs
	output logic o_irq_pending,
	output logic o_accept_busy,
	output pilc_pkg::pilc_push_t o_push,
	output logic o_pc_load,
	output logic [15:0] o_vector,
	output logic o_sp_load,
	output logic [15:0] o_sp_next,
	output logic o_master_enable
);
	import pilc_pkg::*;

	// A shorter sequence leaves no room for the three pushes and the jump
	if (ACCEPT_CYCLES < PUSH_BYTES + 2 || ACCEPT_CYCLES > 8) begin : g_chk
		$error("ACCEPT_CYCLES must lie between 5 and 8");
	end

	localparam logic [2:0] LAST_STEP = 3'(ACCEPT_CYCLES - 1);

	// Vector of a latch index
	function automatic logic [15:0] vec_of(input logic [IDX_W-1:0] idx);
		logic [15:0] off;
		off = 16'h0000;
		if (idx == IDX_W'(SRC_TRAP)) begin
			vec_of = VEC_TRAP;
		end else if (idx == IDX_W'(SRC_WDOG)) begin
			vec_of = VEC_WDOG;
		end else if (idx < IDX_W'(SRC_BANK2)) begin
			off = {10'h000, idx - IDX_W'(SRC_FIRST_MASKABLE), 1'b0};
			vec_of = VEC_BANK1_TOP - off;
		end else begin
			off = {10'h000, idx - IDX_W'(SRC_BANK2), 1'b0};
			vec_of = VEC_BANK2_TOP - off;
		end
	endfunction

	// Lowest index wins; lower index means higher priority
	function automatic logic [IDX_W:0] first_set(input logic [23:0] v);
		first_set = '0;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (v[i]) begin
				first_set = {1'b1, IDX_W'(i)};
			end
		end
	endfunction

	// Byte lane of a 24-bit word by SFR address
	function automatic logic [7:0] lane_of(input logic [23:0] w,
			input logic [7:0] addr, input logic [7:0] a_lo,
			input logic [7:0] a_hi, input logic [7:0] a_up);
		lane_of = 8'h00;
		if (addr == a_lo) begin
			lane_of = w[7:0];
		end else if (addr == a_hi) begin
			lane_of = w[15:8];
		end else if (addr == a_up) begin
			lane_of = w[23:16];
		end
	endfunction

	logic [23:0] latch_q;
	logic [23:0] latch_d;
	logic [23:0] enable_q;
	logic imf_q;
	pilc_state_t state_q;
	logic [2:0] step_q;
	logic [IDX_W-1:0] win_idx_q;
	logic win_soft_q;
	logic [7:0] psw_q;
	logic [15:0] pc_q;
	logic [15:0] sp_q;

	logic [23:0] eligible;
	logic [23:0] maskable_ok;
	logic [IDX_W:0] pick;
	logic soft_req;
	logic take;
	logic [23:0] sw_clear;
	logic [23:0] acc_clear;
	logic [23:0] enable_wmask;
	logic [23:0] enable_wdata;
	logic [7:0] rd_mux;

	// Software and bad-opcode requests are taken only at an instruction end
	assign soft_req = i_software_irq | i_bad_opcode_irq;

	always_comb begin
		maskable_ok = enable_q & {24{imf_q}} & ENABLE_IMPL_MASK;
		maskable_ok[SRC_EXT0] = maskable_ok[SRC_EXT0] & i_ext0_pin_enable;
		// Trap and watchdog bypass both enables
		maskable_ok[SRC_TRAP] = 1'b1;
		maskable_ok[SRC_WDOG] = 1'b1;
		eligible = latch_q & maskable_ok & LATCH_IMPL_MASK;
	end

	assign pick = first_set(eligible);
	assign take = i_ce && state_q == ST_IDLE && i_insn_done &&
		(pick[IDX_W] || soft_req);

	// Latch clears from software: a zero bit clears, a one bit keeps
	always_comb begin
		sw_clear = '0;
		if (i_sfr.wr) begin
			unique case (i_sfr.addr)
				ADDR_LATCH_LOW: sw_clear[7:0] = ~i_sfr.wdata;
				ADDR_LATCH_HIGH: sw_clear[15:8] = ~i_sfr.wdata;
				ADDR_LATCH_UPPER: sw_clear[23:16] = ~i_sfr.wdata;
				default: sw_clear = '0;
			endcase
		end
	end

	// The accepted latch is cleared in the take cycle itself
	always_comb begin
		acc_clear = '0;
		if (take && !soft_req) begin
			acc_clear[pick[IDX_W-1:0]] = 1'b1;
		end
	end

	// A same-cycle request always survives the clear, so the
	// converter-done latch is never dropped by a lower acceptance
	assign latch_d = ((latch_q & ~sw_clear & ~acc_clear) | i_src_req)
		& LATCH_IMPL_MASK;

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			latch_q <= LATCH_RESET;
		end else if (i_ce) begin
			latch_q <= latch_d;
		end
	end

	// Enable flags; bits without a flag stay zero
	always_comb begin
		enable_wmask = '0;
		enable_wdata = '0;
		if (i_sfr.wr) begin
			unique case (i_sfr.addr)
				ADDR_ENABLE_LOW: begin
					enable_wmask[7:0] = 8'hFF;
					enable_wdata[7:0] = i_sfr.wdata;
				end
				ADDR_ENABLE_HIGH: begin
					enable_wmask[15:8] = 8'hFF;
					enable_wdata[15:8] = i_sfr.wdata;
				end
				ADDR_ENABLE_UPPER: begin
					enable_wmask[23:16] = 8'hFF;
					enable_wdata[23:16] = i_sfr.wdata;
				end
				default: enable_wmask = '0;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			enable_q <= ENABLE_RESET;
		end else if (i_ce) begin
			enable_q <= ((enable_q & ~enable_wmask) |
				(enable_wdata & enable_wmask)) & ENABLE_IMPL_MASK;
		end
	end

	// Master enable: acceptance beats return, return beats enable/disable
	// ops, which beat a plain register write
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			imf_q <= RESET_MASTER_ENABLE;
		end else if (i_ce) begin
			if (take) begin
				imf_q <= 1'b0;
			end else if (i_return_op) begin
				imf_q <= i_return_imf;
			end else if (i_disable_op) begin
				imf_q <= 1'b0;
			end else if (i_enable_op) begin
				imf_q <= 1'b1;
			end else if (i_sfr.wr && i_sfr.addr == ADDR_ENABLE_LOW) begin
				imf_q <= i_sfr.wdata[MASTER_ENABLE_BIT];
			end
		end
	end

	// Register read-back
	always_comb begin
		rd_mux = lane_of(latch_q, i_sfr.addr, ADDR_LATCH_LOW,
			ADDR_LATCH_HIGH, ADDR_LATCH_UPPER) |
			lane_of(enable_q, i_sfr.addr, ADDR_ENABLE_LOW,
			ADDR_ENABLE_HIGH, ADDR_ENABLE_UPPER);
		if (i_sfr.addr == ADDR_ENABLE_LOW) begin
			rd_mux[MASTER_ENABLE_BIT] = imf_q;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_sfr_rdata <= 8'h00;
		end else if (i_ce && i_sfr.rd) begin
			o_sfr_rdata <= rd_mux;
		end
	end

	// Request line toward the CPU
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_irq_pending <= 1'b0;
			o_master_enable <= RESET_MASTER_ENABLE;
		end else if (i_ce) begin
			o_irq_pending <= |(latch_d & maskable_ok);
			o_master_enable <= imf_q;
		end
	end

	// Acceptance sequencer; captures the context when it starts
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			state_q <= ST_IDLE;
			step_q <= 3'h0;
			win_idx_q <= '0;
			win_soft_q <= 1'b0;
			psw_q <= 8'h00;
			pc_q <= 16'h0000;
			sp_q <= 16'h0000;
		end else if (i_ce) begin
			unique case (state_q)
				ST_IDLE: begin
					if (take) begin
						state_q <= ST_ACCEPT;
						step_q <= 3'h0;
						// Soft traps share the level; served first
						win_soft_q <= soft_req;
						win_idx_q <= pick[IDX_W-1:0];
						psw_q <= i_psw;
						psw_q[PSW_IMF_BIT] <= imf_q;
						pc_q <= i_pc;
						sp_q <= i_sp;
					end
				end
				ST_ACCEPT: begin
					if (step_q == LAST_STEP) begin
						state_q <= ST_IDLE;
						step_q <= 3'h0;
					end else begin
						step_q <= step_q + 3'h1;
					end
				end
			endcase
		end
	end

	// Stack pushes, then jump; one step per machine cycle
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_push <= '0;
		end else if (i_ce) begin
			o_push <= '0;
			if (state_q == ST_ACCEPT) begin
				unique case (step_q)
					STEP_PUSH_PSW: o_push <= '{1'b1, sp_q, psw_q};
					STEP_PUSH_PCH: o_push <= '{1'b1, sp_q - 16'h0001,
						pc_q[15:8]};
					STEP_PUSH_PCL: o_push <= '{1'b1, sp_q - 16'h0002,
						pc_q[7:0]};
					default: o_push <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_pc_load <= 1'b0;
			o_sp_load <= 1'b0;
			o_vector <= VEC_RESET;
			o_sp_next <= 16'h0000;
			o_accept_busy <= 1'b0;
		end else if (i_ce) begin
			o_accept_busy <= take || (state_q == ST_ACCEPT &&
				step_q != LAST_STEP);
			o_pc_load <= 1'b0;
			o_sp_load <= 1'b0;
			if (state_q == ST_ACCEPT && step_q == LAST_STEP) begin
				o_pc_load <= 1'b1;
				o_sp_load <= 1'b1;
				o_sp_next <= sp_q - 16'(PUSH_BYTES);
				o_vector <= win_soft_q ? VEC_SOFT : vec_of(win_idx_q);
			end
		end
	end

endmodule

// >>> verif/pilc_properties.sv
// Port-level checks for the interrupt latch controller
`timescale 1ns/1ps
module pilc_properties #(
	parameter int ACCEPT_CYCLES = 8
) (
	// Clock and register bus
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire pilc_pkg::pilc_sfr_t i_sfr,
	input wire logic [7:0] o_sfr_rdata,
	// Acceptance
	input wire logic o_accept_busy,
	input wire pilc_pkg::pilc_push_t o_push,
	input wire logic o_pc_load,
	input wire logic [15:0] o_vector,
	input wire logic o_sp_load,
	input wire logic o_master_enable
);
	import pilc_pkg::*;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	logic mapped;
	assign mapped = i_sfr.addr inside {ADDR_ENABLE_UPPER, ADDR_LATCH_UPPER,
		ADDR_ENABLE_LOW, ADDR_ENABLE_HIGH, ADDR_LATCH_LOW, ADDR_LATCH_HIGH};
	sequence s_take;
		!o_accept_busy ##1 o_accept_busy;
	endsequence
	sequence s_push3;
		!o_push.we ##1 o_push.we [*3] ##1 !o_push.we;
	endsequence
	// The first push is launched two cycles after busy shows
	push_order_a: assert property (s_take |-> ##1 s_push3)
		else $error("stack writes not three in a row");
	push_step_a: assert property (o_push.we && $past(o_push.we) |->
		o_push.addr == $past(o_push.addr) - 16'h0001)
		else $error("stack address not descending");
	load_time_a: assert property (s_take |->
		##ACCEPT_CYCLES o_pc_load)
		else $error("vector load late or early");
	load_once_a: assert property (o_pc_load |=> !o_pc_load)
		else $error("vector load longer than one cycle");
	// The enable output is a registered copy, one cycle behind
	enable_clear_a: assert property (s_take |=> !o_master_enable)
		else $error("master enable kept on acceptance");
	load_pair_a: assert property (o_pc_load |->
		o_sp_load && !o_accept_busy)
		else $error("pc and sp loads apart");
	vector_map_a: assert property (o_pc_load |-> !o_vector[0] &&
		o_vector != VEC_RESET && (o_vector >= 16'hFFE0 ||
		(o_vector >= 16'hFFB0 && o_vector <= 16'hFFBE)))
		else $error("vector outside table");
	unmapped_read_a: assert property (i_ce && i_sfr.rd && !mapped |=>
		o_sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	low_bits_a: assert property (i_ce && i_sfr.rd &&
		i_sfr.addr == ADDR_LATCH_LOW |=> o_sfr_rdata[1:0] == 2'b00)
		else $error("latch bits 0 and 1 not zero");
	reset_vec_a: assert property ($rose(i_rstn) |->
		o_vector == VEC_RESET && !o_accept_busy)
		else $error("reset state wrong");
endmodule
bind pilc_top pilc_properties #(.ACCEPT_CYCLES(ACCEPT_CYCLES)) u_props (
	.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce), .i_sfr(i_sfr),
	.o_sfr_rdata(o_sfr_rdata), .o_accept_busy(o_accept_busy),
	.o_push(o_push), .o_pc_load(o_pc_load), .o_vector(o_vector),
	.o_sp_load(o_sp_load), .o_master_enable(o_master_enable));

// >>> verif/pilc_cpu_model.sv
// CPU core stand-in: follows vector and stack loads, logs stack writes
`timescale 1ns/1ps
module pilc_cpu_model (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire pilc_pkg::pilc_push_t i_push,
	input wire logic i_pc_load,
	input wire logic [15:0] i_vector,
	input wire logic [15:0] i_sp_next,
	output logic [15:0] o_pc,
	output logic [15:0] o_sp,
	output logic [2:0][23:0] o_log
);
	logic [1:0] n_q;
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_pc <= 16'h1234;
			o_sp <= 16'h0400;
			n_q <= 2'h0;
		end else if (i_pc_load) begin
			o_pc <= i_vector;
			o_sp <= i_sp_next;
			n_q <= 2'h0;
		end else if (i_push.we) begin
			// Log in arrival order so push order is visible
			o_log[n_q] <= {i_push.addr, i_push.data};
			n_q <= n_q + 2'h1;
		end
	end
endmodule

// >>> verif/tb_top.sv
// Self-checking bench for the interrupt latch controller
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
	$display("FAIL t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
	import pilc_pkg::*;
	logic i_clk = 0, i_rstn = 0, i_ce = 1, i_sw = 0, i_bad = 0, i_pin = 0;
	logic i_done = 0, i_en = 0, i_dis = 0, i_ret = 0, i_rimf = 0;
	logic [23:0] i_req = '0, m_lat, m_en, r;
	logic [7:0] i_psw = '0, rdata, d, a;
	logic [15:0] vec, spn, pc, sp;
	logic pend, busy, pcl, spl, me, m_me;
	logic [2:0][23:0] log;
	pilc_sfr_t i_sfr = '0;
	pilc_push_t push;
	int n_errors = 0, num_checks = 0;
	pilc_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_ce(i_ce),
		.i_src_req(i_req), .i_software_irq(i_sw), .i_bad_opcode_irq(i_bad),
		.i_ext0_pin_enable(i_pin), .i_sfr(i_sfr), .o_sfr_rdata(rdata),
		.i_insn_done(i_done), .i_enable_op(i_en), .i_disable_op(i_dis),
		.i_return_op(i_ret), .i_return_imf(i_rimf), .i_psw(i_psw),
		.i_pc(pc), .i_sp(sp), .o_irq_pending(pend), .o_accept_busy(busy),
		.o_push(push), .o_pc_load(pcl), .o_vector(vec), .o_sp_load(spl),
		.o_sp_next(spn), .o_master_enable(me));
	pilc_cpu_model cpu (.i_clk(i_clk), .i_rstn(i_rstn), .i_push(push),
		.i_pc_load(pcl), .i_vector(vec), .i_sp_next(spn), .o_pc(pc),
		.o_sp(sp), .o_log(log));
	always #2.5 i_clk = ~i_clk;
	task step;
		@(posedge i_clk);
		#1;
	endtask
	task stop_test;
		if (n_errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task rd(input logic [7:0] ad, input logic [7:0] e);
		i_sfr = '{1'b1, 1'b0, ad, 8'h00};
		step;
		`CHK(rdata, e)
		// Idle edge so the next access never re-drives in this step
		i_sfr = '0;
		step;
	endtask
	// Clear applies before the set so a coincident request survives
	task wr(input logic [7:0] ad, input logic [7:0] dv, input logic [23:0] q);
		i_sfr = '{1'b0, 1'b1, ad, dv};
		i_req = q;
		step;
		i_sfr = '0;
		i_req = '0;
		step;
		case (ad)
			ADDR_LATCH_LOW: m_lat[7:0] &= dv;
			ADDR_LATCH_HIGH: m_lat[15:8] &= dv;
			ADDR_LATCH_UPPER: m_lat[23:16] &= dv;
			ADDR_ENABLE_LOW: {m_en[7:0], m_me} = {dv, dv[0]};
			ADDR_ENABLE_HIGH: m_en[15:8] = dv;
			ADDR_ENABLE_UPPER: m_en[23:16] = dv;
			default: ;
		endcase
		m_lat = (m_lat | q) & LATCH_IMPL_MASK;
		m_en &= ENABLE_IMPL_MASK;
	endtask
	task chk;
		rd(ADDR_LATCH_LOW, m_lat[7:0]);
		rd(ADDR_LATCH_HIGH, m_lat[15:8]);
		rd(ADDR_LATCH_UPPER, m_lat[23:16]);
		rd(ADDR_ENABLE_LOW, {m_en[7:1], m_me});
		rd(ADDR_ENABLE_HIGH, m_en[15:8]);
		rd(ADDR_ENABLE_UPPER, m_en[23:16]);
		`CHK(pend, win() != 99)
		`CHK(me, m_me)
	endtask
	function automatic int win();
		for (int n = 2; n < NUM_SRC; n++)
			if (m_lat[n] && (n < 4 || (m_me && m_en[n] && (n != 4 || i_pin))))
				return n;
		return 99;
	endfunction
	task acc(input int s);
		int n;
		int k;
		logic [15:0] v, p, q;
		logic [7:0] f;
		n = (s == 1 || s == 2) ? 1 : win();
		v = n == 1 ? VEC_SOFT : n < 16 ? 16'hFFFE - 16'(2 * n) :
			16'hFFBE - 16'(2 * (n - 16));
		{p, q, f} = {pc, sp, i_psw[7:1], m_me};
		{i_done, i_sw, i_bad} = {1'b1, s == 1, s == 2};
		step;
		{i_done, i_sw, i_bad} = 3'b000;
		if (n == 99) begin
			step;
			`CHK(busy, 1'b0)
			return;
		end
		for (k = 0; k < 20 && pcl !== 1'b1; k++)
			step;
		`CHK(pcl, 1'b1)
		`CHK(k, ACCEPT_MACHINE_CYCLES)
		`CHK(spl, 1'b1)
		`CHK(vec, v)
		`CHK(spn, q - 16'h0003)
		`CHK(log[0], {q, f})
		`CHK(log[1], {q - 16'h0001, p[15:8]})
		`CHK(log[2], {q - 16'h0002, p[7:0]})
		if (n != 1)
			m_lat[n] = 1'b0;
		m_me = 1'b0;
	endtask
	task op(input logic [2:0] c, input logic b);
		{i_en, i_dis, i_ret, i_rimf} = {c, b};
		step;
		{i_en, i_dis, i_ret} = 3'b000;
		m_me = c[2] ? 1'b1 : c[1] ? 1'b0 : b;
	endtask
	initial begin
		#100000;
		n_errors++;
		stop_test;
	end
	initial begin
		void'($urandom(85));
		repeat (2) step;
		i_rstn = 1'b1;
		{m_lat, m_en, m_me} = '0;
		chk;
		rd(ADDR_ENABLE_HIGH, 8'h00);
		rd(8'h10, 8'h00);
		for (int i = 0; i < 200; i++) begin
			// Trap and watchdog pulses assume output selects cleared
			r = $urandom & $urandom & LATCH_IMPL_MASK;
			wr(8'h10, 8'hFF, r);
			a = i % 3 == 0 ? ADDR_LATCH_LOW : i % 3 == 1 ? ADDR_LATCH_HIGH :
				ADDR_LATCH_UPPER;
			d = $urandom;
			// Random clearing write, ones kept over latches 2 and 3
			wr(a, a == ADDR_LATCH_LOW ? d | 8'h0C : d, i % 4 == 0 ? r : '0);
			if (i % 8 == 0) begin
				wr(ADDR_ENABLE_LOW, $urandom, '0);
				wr(ADDR_ENABLE_HIGH, $urandom, '0);
				wr(ADDR_ENABLE_UPPER, $urandom, '0);
			end
			{i_psw, i_pin} = $urandom;
			op(3'b100 >> (i % 3), $urandom);
			acc($urandom_range(0, 5));
			chk;
		end
		// Clock enable low: a clearing write and requests leave no trace
		i_ce = 1'b0;
		i_sfr = '{1'b0, 1'b1, ADDR_LATCH_LOW, 8'h00};
		i_req = '1;
		step;
		i_ce = 1'b1;
		i_sfr = '0;
		i_req = '0;
		step;
		chk;
		stop_test;
	end
endmodule
